// File: shared/dsbad_regs.svh
// Address map and field constants for the data-space byte access decoder.
// Assumes inclusion by bare name from the design files.
`ifndef DSBAD_REGS_SVH
`define DSBAD_REGS_SVH
`define DSBAD_AW 16
`define DSBAD_DW 16
`define DSBAD_WIN_BIT 15
`define DSBAD_MEM_BYTES 16'h7800
`define DSBAD_CTRL_LAST 16'h07FF
`define DSBAD_NEAR_W 13
`define DSBAD_NEAR_LAST 16'h1FFF
`define DSBAD_INC_BYTE 16'h0001
`define DSBAD_INC_WORD 16'h0002
`define DSBAD_SIGN_BIT 7
`endif

// File: shared/dsbad_pkg.sv
// Types for the data-space byte access decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package dsbad_pkg;
  typedef enum logic [1:0] {
    DSBAD_REG_NONE,
    DSBAD_REG_BYTE,
    DSBAD_REG_SIGN,
    DSBAD_REG_ZERO
  } dsbad_regop_t;
  typedef enum logic [1:0] {
    DSBAD_REGION_CTRL,
    DSBAD_REGION_RAM,
    DSBAD_REGION_EMPTY,
    DSBAD_REGION_WINDOW
  } dsbad_region_t;
endpackage : dsbad_pkg

// File: rtl/dsbad_addr_gen.sv
// One address generator: forms an effective address and post-increments.
// Assumes the core supplies the pointer value and mode for each cycle.
`include "dsbad_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dsbad_addr_gen (
  input wire logic [`DSBAD_AW-1:0] src_pointer_reg,
  input wire logic direct_mode,
  input wire logic [`DSBAD_AW-1:0] direct_addr,
  input wire logic near_mode,
  input wire logic is_byte,
  output logic [`DSBAD_AW-1:0] eff_addr,
  output logic [`DSBAD_AW-1:0] ptr_post_inc
);
  // Near direct form zero-pads a short field; it cannot reach past 8 Kbyte.
  // near field reach
  always_comb begin
    if (near_mode) begin
      eff_addr = {{(`DSBAD_AW-`DSBAD_NEAR_W){1'b0}},
                  direct_addr[`DSBAD_NEAR_W-1:0]};
    end else if (direct_mode) begin
      eff_addr = direct_addr;
    end else begin
      eff_addr = src_pointer_reg;
    end
  end
  assign ptr_post_inc = src_pointer_reg +
      (is_byte ? `DSBAD_INC_BYTE : `DSBAD_INC_WORD);
endmodule : dsbad_addr_gen
`default_nettype wire

// File: rtl/dsbad_top.sv
// Data-space byte access decoder: two address paths, byte-lane RAM,
// alignment trap and working-register byte merge.
// Assumes the core holds request inputs stable and sampled on sys_clk.
`include "dsbad_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Separate address generators form read and write addresses.
// - Effective addresses are 16-bit byte addresses over 64 Kbytes.
// - Top bit clear selects memory; top bit set selects program window.
// - Reads outside implemented memory return zero, word or byte.
// - Low byte at even address, high byte at following odd address.
// - Post increment adds one for bytes, two for words.
// - Byte read selects byte by address bit zero onto low lane.
// - Two byte lanes share word decode; byte writes touch one lane.
// - Misaligned word read or write raises an address error.
// - Misaligned read completes; misaligned write is suppressed.
// - Byte load changes only the working register low byte.
// - Sign extend widens signed byte; unsigned widen clears high byte.
// - Lowest 2 Kbytes decode to peripheral and control registers.
// - Unimplemented control addresses read as zero.
// - Near region up to 0x1FFF reachable by 13-bit field.
module dsbad_top #(
  parameter int MEM_BYTES = `DSBAD_MEM_BYTES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic rd_req,
  input wire logic rd_byte,
  input wire logic rd_direct,
  input wire logic rd_near,
  input wire logic [`DSBAD_AW-1:0] rd_ptr,
  input wire logic [`DSBAD_AW-1:0] rd_abs,
  input wire logic wr_req,
  input wire logic wr_byte,
  input wire logic wr_direct,
  input wire logic wr_near,
  input wire logic [`DSBAD_AW-1:0] wr_ptr,
  input wire logic [`DSBAD_AW-1:0] wr_abs,
  input wire logic [`DSBAD_DW-1:0] wr_data,
  input wire logic ctrl_hit,
  input wire logic [`DSBAD_DW-1:0] ctrl_rdata,
  input wire logic [`DSBAD_DW-1:0] window_rdata,
  input wire dsbad_pkg::dsbad_regop_t reg_op,
  input wire logic [`DSBAD_DW-1:0] reg_old,
  output logic [`DSBAD_DW-1:0] rd_data_r,
  output logic rd_valid_r,
  output logic [`DSBAD_AW-1:0] rd_ptr_next,
  output logic [`DSBAD_AW-1:0] wr_ptr_next,
  output logic [`DSBAD_AW-1:0] rd_eff_addr,
  output logic [`DSBAD_AW-1:0] wr_eff_addr,
  output logic ctrl_wr_en,
  output logic [1:0] ctrl_wr_lane,
  output logic window_rd_en,
  output logic [`DSBAD_DW-1:0] reg_new_r,
  output logic addr_err_r
);
  localparam int WORDS = MEM_BYTES / 2;
  localparam int WAW = $clog2(WORDS);

  // Memory above the control region must stay below the window half.
  initial begin
    if (MEM_BYTES < 2 * (`DSBAD_CTRL_LAST + 1) || MEM_BYTES > 32768 ||
        MEM_BYTES % 2 != 0) begin
      $error("MEM_BYTES out of range");
    end
  end

  // ----------------------------------------------------------------
  // Region decode
  // ----------------------------------------------------------------
  function automatic dsbad_pkg::dsbad_region_t region_of(
    input logic [`DSBAD_AW-1:0] a
  );
    if (a[`DSBAD_WIN_BIT]) begin
      region_of = dsbad_pkg::DSBAD_REGION_WINDOW;
    end else if (a <= `DSBAD_CTRL_LAST) begin
      region_of = dsbad_pkg::DSBAD_REGION_CTRL;
    end else if (32'(a) < MEM_BYTES) begin
      region_of = dsbad_pkg::DSBAD_REGION_RAM;
    end else begin
      region_of = dsbad_pkg::DSBAD_REGION_EMPTY;
    end
  endfunction : region_of

  dsbad_addr_gen u_rd_gen (
    .src_pointer_reg(rd_ptr),
    .direct_mode(rd_direct),
    .direct_addr(rd_abs),
    .near_mode(rd_near),
    .is_byte(rd_byte),
    .eff_addr(rd_eff_addr),
    .ptr_post_inc(rd_ptr_next)
  );
  dsbad_addr_gen u_wr_gen (
    .src_pointer_reg(wr_ptr),
    .direct_mode(wr_direct),
    .direct_addr(wr_abs),
    .near_mode(wr_near),
    .is_byte(wr_byte),
    .eff_addr(wr_eff_addr),
    .ptr_post_inc(wr_ptr_next)
  );

  dsbad_pkg::dsbad_region_t rd_region;
  dsbad_pkg::dsbad_region_t wr_region;
  logic rd_mis;
  logic wr_mis;
  logic wr_ok;
  logic [1:0] wr_lane;
  logic [WAW-1:0] rd_widx;
  logic [WAW-1:0] wr_widx;
  logic [`DSBAD_DW-1:0] word_sel;
  logic [`DSBAD_DW-1:0] rd_nxt;
  logic [7:0] mem_lo [WORDS];
  logic [7:0] mem_hi [WORDS];

  assign rd_region = region_of(rd_eff_addr);
  assign wr_region = region_of(wr_eff_addr);
  assign rd_mis = rd_req && !rd_byte && rd_eff_addr[0];
  assign wr_mis = wr_req && !wr_byte && wr_eff_addr[0];
  assign wr_ok = wr_req && !wr_mis;
  assign wr_lane = wr_byte ? {wr_eff_addr[0], !wr_eff_addr[0]} : 2'h3;
  assign rd_widx = rd_eff_addr[WAW:1];
  assign wr_widx = wr_eff_addr[WAW:1];
  assign ctrl_wr_en = wr_ok && wr_region == dsbad_pkg::DSBAD_REGION_CTRL;
  assign ctrl_wr_lane = wr_lane;
  assign window_rd_en = rd_req &&
      rd_region == dsbad_pkg::DSBAD_REGION_WINDOW;

  // ----------------------------------------------------------------
  // Byte-lane memory
  // ----------------------------------------------------------------
  // Each lane has its own write strobe so a byte store leaves its
  // neighbour intact; RAM holds no reset to stay a plain array.
  // lane writes
  always_ff @(posedge sys_clk) begin
    if (wr_ok && wr_region == dsbad_pkg::DSBAD_REGION_RAM) begin
      if (wr_lane[0]) begin
        mem_lo[wr_widx] <= wr_byte ? wr_data[7:0] : wr_data[7:0];
      end
      if (wr_lane[1]) begin
        mem_hi[wr_widx] <= wr_byte ? wr_data[7:0] : wr_data[15:8];
      end
    end
  end

  // Word selection by region; empty space reads as zero.
  // zero outside
  always_comb begin
    case (rd_region)
      dsbad_pkg::DSBAD_REGION_RAM: word_sel = {mem_hi[rd_widx],
                                               mem_lo[rd_widx]};
      dsbad_pkg::DSBAD_REGION_CTRL: word_sel = ctrl_hit ? ctrl_rdata :
                                               16'h0000;
      dsbad_pkg::DSBAD_REGION_WINDOW: word_sel = window_rdata;
      default: word_sel = 16'h0000;
    endcase
  end

  assign rd_nxt = rd_byte ? {8'h00, rd_eff_addr[0] ? word_sel[15:8] :
                                    word_sel[7:0]} : word_sel;

  // ----------------------------------------------------------------
  // Read data and register merge
  // ----------------------------------------------------------------
  // A misaligned read still completes, so data is returned anyway.
  // read completes
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_req;
      if (rd_req) begin
        rd_data_r <= rd_nxt;
      end
    end
  end

  // Working-register update for byte load and the widen operations.
  // register merge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_new_r <= 16'h0000;
    end else begin
      case (reg_op)
        dsbad_pkg::DSBAD_REG_BYTE: reg_new_r <= {reg_old[15:8],
                                                 rd_nxt[7:0]};
        dsbad_pkg::DSBAD_REG_SIGN: reg_new_r <=
            {{8{reg_old[`DSBAD_SIGN_BIT]}}, reg_old[7:0]};
        dsbad_pkg::DSBAD_REG_ZERO: reg_new_r <= {8'h00, reg_old[7:0]};
        default: reg_new_r <= reg_old;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address error
  // ----------------------------------------------------------------
  // error pulse
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      addr_err_r <= 1'b0;
    end else begin
      addr_err_r <= rd_mis || wr_mis;
    end
  end

  AST_ERR_PULSE: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rd_mis || wr_mis) |=> addr_err_r)
    else $error("address error not raised");
  AST_ERR_CAUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(rd_mis || wr_mis) |=> !addr_err_r)
    else $error("spurious address error");
  AST_WR_SUPP: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_mis |-> !ctrl_wr_en)
    else $error("misaligned write not suppressed");
  AST_BYTE_LANE: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_req && rd_byte |=> rd_data_r[15:8] == 8'h00)
    else $error("byte read high lane not zero");
  AST_EMPTY_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_req && rd_region == dsbad_pkg::DSBAD_REGION_EMPTY
      |=> rd_data_r == 16'h0000)
    else $error("empty read not zero");
  AST_WIN_SEL: assert property (@(posedge sys_clk) disable iff (!rstn)
      window_rd_en |-> rd_eff_addr[`DSBAD_WIN_BIT])
    else $error("window selected with top bit clear");
  AST_INC: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_ptr_next - rd_ptr == (rd_byte ? 16'h0001 : 16'h0002))
    else $error("bad post increment");
  AST_BYTE_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_op == dsbad_pkg::DSBAD_REG_BYTE
      |=> reg_new_r[15:8] == $past(reg_old[15:8]))
    else $error("byte load touched high byte");
  AST_CTRL_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
      rd_req && rd_region == dsbad_pkg::DSBAD_REGION_CTRL && !ctrl_hit
      |=> rd_data_r == 16'h0000)
    else $error("empty control read not zero");
endmodule : dsbad_top
`default_nettype wire

// File: verification/dsbad_core_model.sv
// Core-side partner: one control register and the program window source.
// Assumes the decoder shows its read address combinationally.
`timescale 1ns/1ps
`default_nettype none
module dsbad_core_model #(
  parameter logic [15:0] CTRL_ADDR = 16'h0020,
  parameter logic [15:0] CTRL_WORD = 16'hC0DE
) (
  input wire logic [15:0] rd_eff_addr,
  output logic ctrl_hit,
  output logic [15:0] ctrl_rdata,
  output logic [15:0] window_rdata
);
  // sparse control region
  // Off a hit the bus carries junk, so the decoder must gate it to zero.
  assign ctrl_hit = (rd_eff_addr[15:1] == CTRL_ADDR[15:1]);
  assign ctrl_rdata = ctrl_hit ? CTRL_WORD : ~CTRL_WORD;
  assign window_rdata = ~rd_eff_addr;
endmodule : dsbad_core_model
`default_nettype wire

// File: verification/tb_data_space_byte_access_decoder.sv
// Self-checking bench for the data-space byte access decoder.
// Assumes the core model answers control and window reads.
`timescale 1ns/1ps
`default_nettype none
module tb_data_space_byte_access_decoder;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic rd_req = 1'b0, rd_byte = 1'b0, rd_direct = 1'b1, rd_near = 1'b0;
  logic wr_req = 1'b0, wr_byte = 1'b0, wr_direct = 1'b1, wr_near = 1'b0;
  logic [15:0] rd_ptr = 16'h0000, rd_abs = 16'h0000, wr_ptr = 16'h0000;
  logic [15:0] wr_abs = 16'h0000, wr_data = 16'h0000, reg_old = 16'h0000;
  dsbad_pkg::dsbad_regop_t reg_op = dsbad_pkg::DSBAD_REG_NONE;
  logic ctrl_hit, ctrl_wr_en, window_rd_en, rd_valid_r, addr_err_r;
  logic [15:0] ctrl_rdata, window_rdata, rd_data_r, reg_new_r;
  logic [15:0] rd_ptr_next, wr_ptr_next, rd_eff_addr, wr_eff_addr;
  logic [1:0] ctrl_wr_lane;
  int err_total = 0;
  int samples_checked = 0;

  dsbad_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .rd_req(rd_req),
    .rd_byte(rd_byte), .rd_direct(rd_direct), .rd_near(rd_near),
    .rd_ptr(rd_ptr), .rd_abs(rd_abs), .wr_req(wr_req), .wr_byte(wr_byte),
    .wr_direct(wr_direct), .wr_near(wr_near), .wr_ptr(wr_ptr),
    .wr_abs(wr_abs), .wr_data(wr_data), .ctrl_hit(ctrl_hit),
    .ctrl_rdata(ctrl_rdata), .window_rdata(window_rdata), .reg_op(reg_op),
    .reg_old(reg_old), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .rd_ptr_next(rd_ptr_next), .wr_ptr_next(wr_ptr_next),
    .rd_eff_addr(rd_eff_addr), .wr_eff_addr(wr_eff_addr),
    .ctrl_wr_en(ctrl_wr_en), .ctrl_wr_lane(ctrl_wr_lane),
    .window_rd_en(window_rd_en), .reg_new_r(reg_new_r),
    .addr_err_r(addr_err_r));
  dsbad_core_model i_core (.rd_eff_addr(rd_eff_addr), .ctrl_hit(ctrl_hit),
    .ctrl_rdata(ctrl_rdata), .window_rdata(window_rdata));

  // Clock at 125 MHz.
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk

  // One write cycle; the error flag is looked at in the answer cycle.
  task automatic wr(input logic [15:0] a, input logic b,
                    input logic [15:0] d, input logic err);
    @(negedge sys_clk);
    wr_req = 1'b1;
    wr_byte = b;
    wr_abs = a;
    wr_data = d;
    @(negedge sys_clk);
    wr_req = 1'b0;
    chk("addr_err_r", {15'h0000, err}, {15'h0000, addr_err_r});
  endtask : wr

  // One read cycle; data and flags are taken in the answer cycle.
  task automatic rd(input logic [15:0] a, input logic b,
                    input logic [15:0] exp, input logic err);
    @(negedge sys_clk);
    rd_req = 1'b1;
    rd_byte = b;
    rd_abs = a;
    @(negedge sys_clk);
    rd_req = 1'b0;
    chk("rd_data_r", exp, rd_data_r);
    chk("rd_valid_r", 16'h0001, {15'h0000, rd_valid_r});
    chk("addr_err_r", {15'h0000, err}, {15'h0000, addr_err_r});
  endtask : rd

  // Lanes, byte placement and byte merge inside RAM.
  // word requests stay even except where misalignment is the test.
  task automatic t_lanes();
    wr(16'h0800, 1'b0, 16'hA55A, 1'b0);
    wr(16'h0801, 1'b1, 16'h003C, 1'b0);
    rd(16'h0800, 1'b0, 16'h3C5A, 1'b0);
    rd(16'h0800, 1'b1, 16'h005A, 1'b0);
    rd(16'h0801, 1'b1, 16'h003C, 1'b0);
  endtask : t_lanes

  // Misaligned words: write dropped, read served, flag one cycle long.
  task automatic t_misalign();
    wr(16'h0802, 1'b0, 16'h1234, 1'b0);
    wr(16'h0803, 1'b0, 16'hFFFF, 1'b1);
    @(negedge sys_clk);
    chk("err pulse", 16'h0000, {15'h0000, addr_err_r});
    rd(16'h0802, 1'b0, 16'h1234, 1'b0);
    rd(16'h0803, 1'b0, 16'h1234, 1'b1);
  endtask : t_misalign

  // Region decode for reads and control-region writes.
  task automatic t_regions();
    rd(16'h0020, 1'b0, 16'hC0DE, 1'b0);
    rd(16'h0100, 1'b0, 16'h0000, 1'b0);
    rd(16'h7800, 1'b0, 16'h0000, 1'b0);
    rd(16'h7801, 1'b1, 16'h0000, 1'b0);
    rd(16'h8002, 1'b0, 16'h7FFD, 1'b0);
    wr_abs = 16'h0021;
    wr_byte = 1'b1;
    wr_req = 1'b1;
    #1 chk("ctrl_wr_lane", 16'h0002, {14'h0000, ctrl_wr_lane});
    chk("ctrl_wr_en", 16'h0001, {15'h0000, ctrl_wr_en});
    @(negedge sys_clk);
    wr_req = 1'b0;
  endtask : t_regions

  // Pointer steps on both generators and near addressing on the read generator.
  task automatic t_agen();
    rd_ptr = 16'hFFFE;
    wr_ptr = 16'h1000;
    rd_byte = 1'b1;
    wr_byte = 1'b0;
    rd_abs = 16'hE802;
    rd_near = 1'b1;
    #1 chk("rd_ptr_next", 16'hFFFF, rd_ptr_next);
    chk("wr_ptr_next", 16'h1002, wr_ptr_next);
    chk("wr_eff_addr", 16'h0021, wr_eff_addr);
    chk("rd_eff_addr", 16'h0802, rd_eff_addr);
    rd_near = 1'b0;
    #1 chk("rd_eff_addr", 16'hE802, rd_eff_addr);
    rd_req = 1'b1;
    #1 chk("window_rd_en", 16'h0001, {15'h0000, window_rd_en});
    rd_req = 1'b0;
  endtask : t_agen

  // Register widening and byte-load operations.
  task automatic rop(input dsbad_pkg::dsbad_regop_t op,
                     input logic [15:0] old, input logic [15:0] exp);
    @(negedge sys_clk);
    reg_op = op;
    reg_old = old;
    @(negedge sys_clk);
    reg_op = dsbad_pkg::DSBAD_REG_NONE;
    chk("reg_new_r", exp, reg_new_r);
  endtask : rop

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog sized well above the roughly fifty cycles the tests need.
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    t_lanes();
    t_misalign();
    t_regions();
    t_agen();
    rop(dsbad_pkg::DSBAD_REG_SIGN, 16'h1285, 16'hFF85);
    rop(dsbad_pkg::DSBAD_REG_SIGN, 16'hAB7F, 16'h007F);
    rop(dsbad_pkg::DSBAD_REG_ZERO, 16'hAB85, 16'h0085);
    // Read side still points at window word 0xE802, whose low byte is FD.
    rop(dsbad_pkg::DSBAD_REG_BYTE, 16'h1234, 16'h12FD);
    stop_test();
  end
endmodule : tb_data_space_byte_access_decoder
`default_nettype wire
